/* sfs_defines.svh */
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH

// ----------------------------------------------------------------
// block layout, stealing mode
// ----------------------------------------------------------------
`define SFS_C0_LEN 8'h52
`define SFS_C2_POS 8'h78
`define SFS_CRC_POS 8'h76
`define SFS_PAR_POS 8'h9c
`define SFS_TAIL_POS 8'ha0
`define SFS_LAST_POS 8'ha3
`define SFS_BLK_LAST 8'hd7
`define SFS_BLK_MOD 16'h00d8
`define SFS_ILV_MULT 16'h0061
`define SFS_SLOT_HALF 9'h0d8
`define SFS_SLOT_LAST 9'h1af

// ----------------------------------------------------------------
// trellis and check positions
// ----------------------------------------------------------------
`define SFS_TRL_LAST 7'h51
`define SFS_C1_STEPS 7'h26
`define SFS_CHK_FIRST 7'h24
`define SFS_CHK_LAST 7'h49
`define SFS_PAR_IDX 7'h4a
`define SFS_PM_INF 9'h100

// ----------------------------------------------------------------
// crc, puncturing masks, fill values, output framing
// ----------------------------------------------------------------
`define SFS_CRC_FOLD 4'h3
`define SFS_KEEP_C1_EVEN 3'b011
`define SFS_KEEP_C1_ODD 3'b001
`define SFS_KEEP_C2_0 3'b011
`define SFS_KEEP_C2_1 3'b011
`define SFS_KEEP_C2_2 3'b111
`define SFS_KEEP_C2_3 3'b000
`define SFS_FIX_VAL 34'h2_14f4_d0c9
`define SFS_FIX_POS 8'h9c
`define SFS_FIX_TOP 8'hbd
`define SFS_OUT_LAST 8'hbd
`define SFS_FIFO_DEPTH 8

`endif

/* sfs_pkg.sv */
`include "sfs_defines.svh"

package sfs_pkg;

    typedef enum logic [1:0] {SFS_TX_LOAD, SFS_TX_TAIL, SFS_TX_SEND} sfs_tx_type;
    typedef enum logic [2:0] {
        SFS_RX_LOAD, SFS_RX_ACS, SFS_RX_TB, SFS_RX_CHK, SFS_RX_CMP, SFS_RX_EMIT
    } sfs_rx_type;

    // mother code outputs {g3, g2, g1}; st[0] is the newest past bit
    function automatic logic [2:0] sfs_mother(input logic [3:0] st, input logic b);
        sfs_mother[0] = b ^ st[0] ^ st[1] ^ st[2] ^ st[3];
        sfs_mother[1] = b ^ st[0] ^ st[2] ^ st[3];
        sfs_mother[2] = b ^ st[1] ^ st[3];
    endfunction

    // kept mother outputs for one input bit
    function automatic logic [2:0] sfs_keep(input logic cls2, input logic [1:0] ph);
        if (!cls2) begin
            sfs_keep = ph[0] ? `SFS_KEEP_C1_ODD : `SFS_KEEP_C1_EVEN;
        end else begin
            unique case (ph)
                2'h0: sfs_keep = `SFS_KEEP_C2_0;
                2'h1: sfs_keep = `SFS_KEEP_C2_1;
                2'h2: sfs_keep = `SFS_KEEP_C2_2;
                2'h3: sfs_keep = `SFS_KEEP_C2_3;
            endcase
        end
    endfunction

    // interleaver position of block bit k
    function automatic logic [7:0] sfs_perm(input logic [7:0] k);
        logic [15:0] t;
        t = {8'h00, k} * `SFS_ILV_MULT;
        sfs_perm = 8'(t % `SFS_BLK_MOD);
    endfunction

    function automatic logic [1:0] sfs_wt(input logic [2:0] v);
        sfs_wt = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
    endfunction

endpackage

/* sfs_stream_if.sv */
`timescale 1ns/1ps

interface sfs_stream_if #(parameter int W = 2) ();
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

/* sfs_fifo.sv */
`timescale 1ns/1ps

module sfs_fifo #(
    parameter int W = 2,
    parameter int D = 8
) (
    input wire logic clk_sys,
    input wire logic nrst,
    sfs_stream_if.snk in_if,
    sfs_stream_if.src out_if
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic empty;

    // pointer compare with wrap bit
    assign empty = wr_q == rd_q;
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign in_if.ready = !full;
    assign out_if.valid = !empty;
    assign out_if.data = mem_q[rd_q[AW-1:0]];

    // storage
    always_ff @(posedge clk_sys) begin
        if (in_if.valid && !full) begin
            mem_q[wr_q[AW-1:0]] <= in_if.data;
        end
    end

    // pointers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (in_if.valid && !full) wr_q <= wr_q + 1'b1;
            if (out_if.ready && !empty) rd_q <= rd_q + 1'b1;
        end
    end
endmodule

/* sfs_crc4.sv */
`timescale 1ns/1ps
`include "sfs_defines.svh"

module sfs_crc4 (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clr,
    input wire logic en,
    input wire logic din,
    output logic [3:0] crc
);
    logic [3:0] pw_q;

    // bits arrive lowest degree first: add x^(n+4) mod g per one bit
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            crc <= 4'h0;
            pw_q <= `SFS_CRC_FOLD;
        end else if (clr) begin
            crc <= 4'h0;
            pw_q <= `SFS_CRC_FOLD;
        end else if (en) begin
            if (din) crc <= crc ^ pw_q;
            pw_q <= {pw_q[2:0], 1'b0} ^ (pw_q[3] ? `SFS_CRC_FOLD : 4'h0);
        end
    end
endmodule

/* sfs_speech_fec_frame_steal.sv */
`timescale 1ns/1ps
`include "sfs_defines.svh"

module sfs_speech_fec_frame_steal
    import sfs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic tx_bit,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic mod_bit,
    output logic mod_valid,
    input wire logic mod_ready,
    input wire logic rx_bit,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic rx_steal,
    output logic dec_bit,
    output logic dec_last,
    output logic dec_valid,
    input wire logic dec_ready,
    output logic bad_frame_flag,
    output logic normal_slot
);

    // ----------------------------------------------------------------
    // transmit: coding and interleaving
    // ----------------------------------------------------------------
    sfs_tx_type tx_st_q;
    logic [7:0] tx_pos_q;
    logic [7:0] tx_oidx_q;
    logic [7:0] tx_sidx_q;
    logic [3:0] tx_sr_q;
    logic tx_buf_q [216];
    logic [3:0] tx_crc;
    logic tx_fire;
    logic tx_c0;
    logic tx_c2;
    logic enc_bit;
    logic [2:0] enc_out;
    logic [2:0] tx_mask;
    logic [2:0] tx_vals;
    logic [1:0] toff;
    logic [2:0] tx_we;
    logic [7:0] tx_wa [3];
    logic tx_send_done;

    assign tx_ready = tx_st_q == SFS_TX_LOAD;
    assign tx_fire = (tx_ready && tx_valid) || (tx_st_q == SFS_TX_TAIL);
    assign tx_c0 = tx_pos_q < `SFS_C0_LEN;
    assign tx_c2 = tx_pos_q >= `SFS_C2_POS;

    // parity then zero tail feed the coder after the class bits
    always_comb begin
        if (tx_st_q == SFS_TX_LOAD) begin
            enc_bit = tx_bit;
        end else if (tx_pos_q < `SFS_TAIL_POS) begin
            enc_bit = tx_crc[2'(tx_pos_q - `SFS_PAR_POS)];
        end else begin
            enc_bit = 1'b0;
        end
    end

    assign enc_out = sfs_mother(tx_sr_q, enc_bit);
    // class 0 takes one plain bit, coded classes take kept outputs
    assign tx_mask = tx_c0 ? 3'b001 :
                     sfs_keep(tx_c2, tx_c2 ? 2'(tx_pos_q - `SFS_C2_POS)
                                           : {1'b0, tx_pos_q[0]});
    assign tx_vals = tx_c0 ? {2'b00, enc_bit} : enc_out;

    // kept bits land at their permuted block positions
    always_comb begin
        toff = 2'h0;
        for (int j = 0; j < 3; j++) begin
            tx_wa[j] = sfs_perm(tx_oidx_q + 8'(toff));
            tx_we[j] = tx_fire && tx_mask[j];
            if (tx_mask[j]) toff = toff + 2'h1;
        end
    end

    sfs_crc4 u_tx_crc (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clr(tx_send_done),
        .en(tx_fire && tx_ready && tx_pos_q >= `SFS_CRC_POS),
        .din(tx_bit),
        .crc(tx_crc)
    );

    // coded block store
    always_ff @(posedge clk_sys) begin
        for (int j = 0; j < 3; j++) begin
            if (tx_we[j]) tx_buf_q[tx_wa[j]] <= tx_vals[j];
        end
    end

    assign tx_send_done = mod_valid && mod_ready && tx_sidx_q == `SFS_BLK_LAST;

    // transmit sequencing
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_st_q <= SFS_TX_LOAD;
            tx_pos_q <= 8'h00;
            tx_oidx_q <= 8'h00;
            tx_sidx_q <= 8'h00;
        end else begin
            unique case (tx_st_q)
                SFS_TX_LOAD, SFS_TX_TAIL: begin
                    if (tx_fire) begin
                        tx_pos_q <= tx_pos_q + 8'h01;
                        tx_oidx_q <= tx_oidx_q + 8'(toff);
                        if (tx_pos_q == `SFS_PAR_POS - 8'h01) tx_st_q <= SFS_TX_TAIL;
                        if (tx_pos_q == `SFS_LAST_POS) tx_st_q <= SFS_TX_SEND;
                    end
                end
                SFS_TX_SEND: begin
                    if (mod_ready) tx_sidx_q <= tx_sidx_q + 8'h01;
                    if (tx_send_done) begin
                        tx_st_q <= SFS_TX_LOAD;
                        tx_pos_q <= 8'h00;
                        tx_oidx_q <= 8'h00;
                        tx_sidx_q <= 8'h00;
                    end
                end
            endcase
        end
    end

    // coder memory: untouched at the class 1 to 2 switch
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_sr_q <= 4'h0;
        end else if (tx_send_done) begin
            tx_sr_q <= 4'h0;
        end else if (tx_fire && !tx_c0) begin
            tx_sr_q <= {tx_sr_q[2:0], enc_bit};
        end
    end

    assign mod_valid = tx_st_q == SFS_TX_SEND;
    assign mod_bit = tx_buf_q[tx_sidx_q];

    // ----------------------------------------------------------------
    // receive: capture, Viterbi, check, deliver
    // ----------------------------------------------------------------
    sfs_rx_type rx_st_q;
    logic [8:0] rx_cnt_q;
    logic steal_q;
    logic rx_buf_q [216];
    logic [6:0] step_q;
    logic [7:0] cidx_q;
    logic [8:0] pm_q [16];
    logic [8:0] pm_d [16];
    logic [15:0] dec_q [82];
    logic [15:0] decs;
    logic [81:0] dbits_q;
    logic [3:0] tb_q;
    logic [7:0] eidx_q;
    logic [3:0] rx_crc;
    logic [2:0] rkeep;
    logic [2:0] rcv;
    logic [1:0] roff;
    logic [8:0] m0;
    logic [8:0] m1;
    logic [3:0] ns;
    logic emit_bit;
    logic rx_acc;
    logic fifo_rdy;

    assign rx_ready = rx_st_q == SFS_RX_LOAD;
    assign rx_acc = rx_ready && rx_valid;

    // slot capture; only the second half is kept when stealing
    always_ff @(posedge clk_sys) begin
        if (rx_acc && steal_q && rx_cnt_q >= `SFS_SLOT_HALF) begin
            rx_buf_q[8'(rx_cnt_q - `SFS_SLOT_HALF)] <= rx_bit;
        end
    end

    // gather received bits for this step, reading deinterleaved
    assign rkeep = sfs_keep(step_q >= `SFS_C1_STEPS,
                            step_q >= `SFS_C1_STEPS ? 2'(step_q - `SFS_C1_STEPS)
                                                    : {1'b0, step_q[0]});
    always_comb begin
        roff = 2'h0;
        for (int j = 0; j < 3; j++) begin
            rcv[j] = rx_buf_q[sfs_perm(`SFS_C0_LEN + cidx_q + 8'(roff))];
            if (rkeep[j]) roff = roff + 2'h1;
        end
    end

    // add-compare-select; erased outputs carry no metric
    always_comb begin
        m0 = 9'h000;
        m1 = 9'h000;
        ns = 4'h0;
        for (int s = 0; s < 16; s++) begin
            ns = 4'(s);
            m0 = pm_q[{1'b0, ns[3:1]}]
                 + 9'(sfs_wt((sfs_mother({1'b0, ns[3:1]}, ns[0]) ^ rcv) & rkeep));
            m1 = pm_q[{1'b1, ns[3:1]}]
                 + 9'(sfs_wt((sfs_mother({1'b1, ns[3:1]}, ns[0]) ^ rcv) & rkeep));
            decs[s] = m1 < m0;
            pm_d[s] = (m1 < m0) ? m1 : m0;
        end
    end

    // path metrics start in the zero state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int s = 0; s < 16; s++) pm_q[s] <= `SFS_PM_INF;
        end else if (rx_st_q == SFS_RX_LOAD) begin
            for (int s = 0; s < 16; s++) pm_q[s] <= (s == 0) ? 9'h000 : `SFS_PM_INF;
        end else if (rx_st_q == SFS_RX_ACS) begin
            pm_q <= pm_d;
        end
    end

    // survivor decisions per trellis step
    always_ff @(posedge clk_sys) begin
        if (rx_st_q == SFS_RX_ACS) dec_q[step_q] <= decs;
    end

    // traceback from the zero state reached by the tail
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dbits_q <= '0;
            tb_q <= 4'h0;
        end else if (rx_st_q == SFS_RX_ACS) begin
            tb_q <= 4'h0;
        end else if (rx_st_q == SFS_RX_TB) begin
            dbits_q[step_q] <= tb_q[0];
            tb_q <= {dec_q[step_q][tb_q], tb_q[3:1]};
        end
    end

    sfs_crc4 u_rx_crc (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clr(rx_st_q == SFS_RX_LOAD),
        .en(rx_st_q == SFS_RX_CHK),
        .din(dbits_q[step_q]),
        .crc(rx_crc)
    );

    // receive sequencing
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_st_q <= SFS_RX_LOAD;
            rx_cnt_q <= 9'h000;
            steal_q <= 1'b0;
            step_q <= 7'h00;
            cidx_q <= 8'h00;
            eidx_q <= 8'h00;
        end else begin
            unique case (rx_st_q)
                SFS_RX_LOAD: begin
                    if (rx_acc) begin
                        if (rx_cnt_q == 9'h000) steal_q <= rx_steal;
                        rx_cnt_q <= rx_cnt_q + 9'h001;
                        if (rx_cnt_q == `SFS_SLOT_LAST) begin
                            rx_cnt_q <= 9'h000;
                            if (steal_q) rx_st_q <= SFS_RX_ACS;
                        end
                    end
                    step_q <= 7'h00;
                    cidx_q <= 8'h00;
                    eidx_q <= 8'h00;
                end
                SFS_RX_ACS: begin
                    cidx_q <= cidx_q + 8'(roff);
                    if (step_q == `SFS_TRL_LAST) rx_st_q <= SFS_RX_TB;
                    else step_q <= step_q + 7'h01;
                end
                SFS_RX_TB: begin
                    if (step_q == 7'h00) begin
                        rx_st_q <= SFS_RX_CHK;
                        step_q <= `SFS_CHK_FIRST;
                    end else begin
                        step_q <= step_q - 7'h01;
                    end
                end
                SFS_RX_CHK: begin
                    if (step_q == `SFS_CHK_LAST) rx_st_q <= SFS_RX_CMP;
                    else step_q <= step_q + 7'h01;
                end
                SFS_RX_CMP: rx_st_q <= SFS_RX_EMIT;
                SFS_RX_EMIT: begin
                    if (fifo_rdy) begin
                        eidx_q <= eidx_q + 8'h01;
                        if (eidx_q == `SFS_OUT_LAST) rx_st_q <= SFS_RX_LOAD;
                    end
                end
            endcase
        end
    end

    // one pulse per normal slot, which is not decoded here
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            normal_slot <= 1'b0;
        end else begin
            normal_slot <= rx_acc && !steal_q && rx_cnt_q == `SFS_SLOT_LAST;
        end
    end

    // flag compares recomputed and decoded parity
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bad_frame_flag <= 1'b0;
        end else if (rx_st_q == SFS_RX_CMP) begin
            bad_frame_flag <= rx_crc != dbits_q[`SFS_PAR_IDX +: 4];
        end
    end

    // delivered order: plain class, decoded classes, fixed fill
    always_comb begin
        if (eidx_q < `SFS_C0_LEN) begin
            emit_bit = rx_buf_q[sfs_perm(eidx_q)];
        end else if (eidx_q < `SFS_FIX_POS) begin
            emit_bit = dbits_q[7'(eidx_q - `SFS_C0_LEN)];
        end else begin
            emit_bit = 1'(`SFS_FIX_VAL >> (`SFS_FIX_TOP - eidx_q));
        end
    end

    // ----------------------------------------------------------------
    // output buffer toward the speech decoder
    // ----------------------------------------------------------------
    sfs_stream_if #(.W(2)) fill_if ();
    sfs_stream_if #(.W(2)) drain_if ();

    assign fill_if.valid = rx_st_q == SFS_RX_EMIT;
    assign fill_if.data = {eidx_q == `SFS_OUT_LAST, emit_bit};
    assign fifo_rdy = fill_if.ready;

    sfs_fifo #(.W(2), .D(`SFS_FIFO_DEPTH)) u_out_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_if(fill_if),
        .out_if(drain_if)
    );

    assign dec_valid = drain_if.valid;
    assign dec_bit = drain_if.data[0];
    assign dec_last = drain_if.data[1];
    assign drain_if.ready = dec_ready;

endmodule

/* sfs_speech_fec_frame_steal_monitor.sv */
`timescale 1ns/1ps
// ----------------
// port checks
// ----------------
module sfs_speech_fec_frame_steal_monitor (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic tx_bit,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic mod_bit,
    input wire logic mod_valid,
    input wire logic mod_ready,
    input wire logic rx_bit,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rx_steal,
    input wire logic dec_bit,
    input wire logic dec_last,
    input wire logic dec_valid,
    input wire logic dec_ready,
    input wire logic bad_frame_flag,
    input wire logic normal_slot
);
    logic [7:0] tx_n_q;
    logic [7:0] mod_n_q;
    logic [7:0] dec_n_q;
    logic [8:0] rx_n_q;
    logic steal_q;
    wire tx_go = tx_valid && tx_ready;
    wire mod_go = mod_valid && mod_ready;
    wire rx_go = rx_valid && rx_ready;
    wire dec_go = dec_valid && dec_ready;
    wire rx_end = rx_go && rx_n_q == 9'h1af;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // transfer counters per stream, wrapping at each stream's frame, block or slot length
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_n_q <= 8'h00;
            mod_n_q <= 8'h00;
            dec_n_q <= 8'h00;
            rx_n_q <= 9'h000;
            steal_q <= 1'b0;
        end else begin
            if (tx_go) tx_n_q <= (tx_n_q == 8'h9b) ? 8'h00 : tx_n_q + 8'h01;
            if (mod_go) mod_n_q <= (mod_n_q == 8'hd7) ? 8'h00 : mod_n_q + 8'h01;
            if (dec_go) dec_n_q <= (dec_n_q == 8'hbd) ? 8'h00 : dec_n_q + 8'h01;
            if (rx_go) rx_n_q <= (rx_n_q == 9'h1af) ? 9'h000 : rx_n_q + 9'h001;
            if (rx_go && rx_n_q == 9'h000) steal_q <= rx_steal;
        end
    end

    a_tail_gap: assert property (tx_go && tx_n_q == 8'h9b
        |=> (!tx_ready && !mod_valid) [*8] ##1 mod_valid) else $error("tail gap wrong");
    a_block_len: assert property (mod_go && mod_n_q == 8'hd7
        |=> tx_ready && !mod_valid) else $error("coded block length wrong");
    a_mod_hold: assert property (mod_valid && !mod_ready
        |=> mod_valid && $stable(mod_bit)) else $error("coded bit not held");
    a_slot_pulse: assert property (rx_end && !steal_q
        |=> normal_slot ##1 !normal_slot) else $error("slot pulse wrong");
    a_no_output: assert property (rx_end && !steal_q
        |=> !dec_valid [*8]) else $error("normal slot delivered bits");
    a_rx_hold: assert property (rx_end && steal_q
        |=> !rx_ready [*8]) else $error("slot taken during decode");
    a_decode_time: assert property (rx_end && steal_q
        |=> !dec_valid [*8] ##[150:260] dec_valid) else $error("decode time wrong");
    a_last_pos: assert property (dec_go
        |-> dec_last == (dec_n_q == 8'hbd)) else $error("last marker misplaced");
    a_flag_hold: assert property (dec_go && dec_n_q != 8'h00
        |-> $stable(bad_frame_flag)) else $error("flag moved in frame");
    a_dec_hold: assert property (dec_valid && !dec_ready
        |=> dec_valid && $stable(dec_bit) && $stable(dec_last)) else $error("output not held");
endmodule

bind sfs_speech_fec_frame_steal sfs_speech_fec_frame_steal_monitor u_mon (
    .clk_sys(clk_sys), .nrst(nrst), .tx_bit(tx_bit), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .mod_bit(mod_bit), .mod_valid(mod_valid), .mod_ready(mod_ready),
    .rx_bit(rx_bit), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_steal(rx_steal),
    .dec_bit(dec_bit), .dec_last(dec_last), .dec_valid(dec_valid), .dec_ready(dec_ready),
    .bad_frame_flag(bad_frame_flag), .normal_slot(normal_slot)
);

/* sfs_modem_model.sv */
`timescale 1ns/1ps
// ----------------
// modulator sink and demodulator source
// ----------------
module sfs_modem_model (
    input wire logic clk_sys,
    input wire logic mod_bit,
    input wire logic mod_valid,
    output logic mod_ready,
    output logic rx_bit,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_steal
);
    logic [215:0] cap;
    int n = 0;
    int cyc = 0;

    initial begin
        mod_ready = 1'b0;
        rx_bit = 1'b0;
        rx_valid = 1'b0;
        rx_steal = 1'b0;
    end

    // capture coded bits; stall every third cycle
    always @(posedge clk_sys) begin
        if (mod_valid && mod_ready) begin
            cap[n] = mod_bit;
            n = (n + 1) % 216;
        end
        cyc = cyc + 1;
        #1;
        mod_ready = (cyc % 3 != 0);
    end

    // one slot; first half toggles, released line inverted
    task automatic send_slot(input logic steal, input logic [215:0] blk);
        int i;
        for (i = 0; i < 432; i++) begin
            rx_steal = steal;
            rx_valid = 1'b1;
            rx_bit = (i < 216) ? i[0] : blk[i - 216];
            do @(posedge clk_sys); while (!rx_ready);
            #1;
        end
        rx_valid = 1'b0;
        rx_bit = ~rx_bit;
    endtask
endmodule

/* sfs_speech_fec_frame_steal_tb_top.sv */
`timescale 1ns/1ps
module sfs_speech_fec_frame_steal_tb_top;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic tx_bit = 1'b0;
    logic tx_valid = 1'b0;
    logic dec_ready = 1'b0;
    wire tx_ready, mod_bit, mod_valid, mod_ready, rx_bit, rx_valid, rx_ready, rx_steal;
    wire dec_bit, dec_last, dec_valid, bad_frame_flag, normal_slot;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    // frame a and b fill bits, s62 first
    localparam logic [33:0] fill_val = {4'h8, 1'h0, 3'h5, 3'h1, 2'h3, 8'ha6, 4'h8,
        1'h0, 3'h6, 3'h2, 1'h0, 1'h1};
    localparam logic [155:0] pay_a = {6{26'h2a59c3e}};
    localparam logic [155:0] pay_b = {12{13'h1b2d}};

    always #2.5 clk_sys = ~clk_sys;

    sfs_speech_fec_frame_steal u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .tx_bit(tx_bit), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .mod_bit(mod_bit), .mod_valid(mod_valid), .mod_ready(mod_ready),
        .rx_bit(rx_bit), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_steal(rx_steal),
        .dec_bit(dec_bit), .dec_last(dec_last), .dec_valid(dec_valid), .dec_ready(dec_ready),
        .bad_frame_flag(bad_frame_flag), .normal_slot(normal_slot)
    );
    sfs_modem_model u_modem (
        .clk_sys(clk_sys), .mod_bit(mod_bit), .mod_valid(mod_valid), .mod_ready(mod_ready),
        .rx_bit(rx_bit), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_steal(rx_steal)
    );

    // ----------------
    // checking helpers and reference coder
    // ----------------
    task stop_test();
        if (mismatches == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task chk(input logic [215:0] got, input logic [215:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    // remainder of x^4 i(x), highest degree fed first
    function automatic logic [3:0] crc4(input logic [155:0] p);
        logic [3:0] r;
        int i;
        r = 4'h0;
        for (i = 155; i >= 118; i--) r = {r[2:0], 1'b0} ^ ((r[3] ^ p[i]) ? 4'h3 : 4'h0);
        return r;
    endfunction

    function automatic logic [159:0] mk(input logic [155:0] p, input logic bad);
        return {crc4(p) ^ {3'h0, bad}, p};
    endfunction

    // plain class 0, punctured mother code, then interleave
    function automatic logic [215:0] encode(input logic [159:0] t);
        logic [215:0] c;
        logic [215:0] o;
        logic [3:0] s;
        logic [2:0] g;
        logic b;
        int k;
        int n;
        int ph;
        s = 4'h0;
        n = 82;
        c[81:0] = t[81:0];
        for (k = 82; k < 164; k++) begin
            b = (k < 160) ? t[k] : 1'b0;
            g = {b ^ s[1] ^ s[3], b ^ s[0] ^ s[2] ^ s[3], b ^ (^s)};
            ph = (k < 120) ? (k - 82) % 2 : (k - 120) % 4 + 4;
            if (ph != 7) begin
                c[n] = g[0];
                n++;
            end
            if (ph != 1 && ph != 7) begin
                c[n] = g[1];
                n++;
            end
            if (ph == 6) begin
                c[n] = g[2];
                n++;
            end
            s = {s[2:0], b};
        end
        for (k = 0; k < 216; k++) o[(97 * k) % 216] = c[k];
        return o;
    endfunction

    // ----------------
    // scenarios
    // ----------------
    task tx_frame(input logic [155:0] p);
        int i;
        for (i = 0; i < 156; i++) begin
            tx_bit = p[i];
            tx_valid = 1'b1;
            do @(posedge clk_sys); while (!tx_ready);
            #1;
        end
        tx_valid = 1'b0;
        tx_bit = ~tx_bit;
        while (mod_valid !== 1'b1) @(posedge clk_sys);
        while (mod_valid === 1'b1) @(posedge clk_sys);
        #1;
        chk(u_modem.cap, encode(mk(p, 1'b0)));
        chk(tx_ready, 1'b1);
    endtask

    task rx_frame(input logic [155:0] p, input logic bad, input logic [215:0] blk);
        int i;
        u_modem.send_slot(1'b1, blk);
        while (dec_valid !== 1'b1) @(posedge clk_sys);
        repeat (20) @(posedge clk_sys);
        #1;
        for (i = 0; i < 190; i++) begin
            dec_ready = 1'b1;
            do @(posedge clk_sys); while (!dec_valid);
            chk(dec_bit, (i < 156) ? p[i] : fill_val[189 - i]);
            chk(dec_last, i == 189);
            chk(bad_frame_flag, bad);
            #1;
            if (i % 9 == 8) begin
                dec_ready = 1'b0;
                @(posedge clk_sys);
                #1;
            end
        end
        dec_ready = 1'b0;
    endtask

    task slot_normal();
        int i;
        int seen;
        seen = 0;
        u_modem.send_slot(1'b0, encode(mk(pay_a, 1'b0)));
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (normal_slot === 1'b1) seen++;
        end
        chk(216'(seen), 216'h1);
        chk(dec_valid, 1'b0);
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        #1;
        chk(tx_ready, 1'b1);
        chk(dec_valid, 1'b0);
        nrst = 1'b1;
        tx_frame(pay_a);
        rx_frame(pay_a, 1'b0, u_modem.cap);
        tx_frame(pay_b);
        rx_frame(pay_b, 1'b1, encode(mk(pay_b, 1'b1)));
        slot_normal();
        stop_test();
    end
endmodule
